// file: logic/pbc_consts.vh
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH

// ----------------------------------------
// clock and time base
// ----------------------------------------
`define PBC_CLK_HZ 100000000
`define PBC_MS_PER_S 1000
`define PBC_US_PER_S 1000000
`define PBC_DISCHARGE_US 30

// ----------------------------------------
// debounce times, ms
// ----------------------------------------
`define PBC_DBNC_RISE_MS 10'h020
`define PBC_DBNC_32_MS 10'h020
`define PBC_DBNC_125_MS 10'h07D
`define PBC_DBNC_750_MS 10'h2EE

// ----------------------------------------
// hold and long-press times, ms
// ----------------------------------------
`define PBC_HOLD_1S_MS 14'h03E8
`define PBC_HOLD_2S_MS 14'h07D0
`define PBC_HOLD_3S_MS 14'h0BB8
`define PBC_HOLD_4S_MS 14'h0FA0
`define PBC_HOLD_8S_MS 14'h1F40
`define PBC_HOLD_16S_MS 14'h3E80
`define PBC_HOLD_MAX 14'h3FFF

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PBC_ADDR_IRQ_STATUS 8'h00
`define PBC_ADDR_IRQ_MASK 8'h04
`define PBC_ADDR_SENSE 8'h08
`define PBC_ADDR_CTRL 8'h0C

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define PBC_IRQ_PRESS 0
`define PBC_IRQ_RELEASE 1
`define PBC_IRQ_HOLD_BASE 2
`define PBC_IRQ_WIDTH 7
`define PBC_MASK_RESET 7'h7F
`define PBC_SENSE_BIT 0
`define PBC_SENSE_MODE 1
`define PBC_CTRL_DBNC_LO 0
`define PBC_CTRL_DELAY_LO 2
`define PBC_CTRL_RSTSEL 4
`define PBC_RSTSEL_RESET 1'h0

`endif

// file: logic/pbc_power_button_controller.v
`timescale 1ns/1ps
`include "pbc_consts.vh"

// Behaviour
// - level mode: pin low keeps device off
// - level mode: power-on only while pin high
// - button mode: pin is push button, low pressed
// - sense bit is inverse of pin
// - debounce: rise 32ms, fall per select
// - debounce select loaded from default at reset
// - system-off: debounced press starts power-on event
// - system-on: debounced press sets press latch
// - system-on: debounced release sets release latch
// - hold latches at 1,2,3,4,8 seconds
// - long press with reset select forces reset
// - reset: power down, wait 30us, power up
// - long press without reset select turns off
// - delay select loaded from default at reset
// - latches sticky, cleared by writing one
// - unmasked set latch pulls irq output low
module pbc_power_button_controller #(
  parameter MS_CYCLES = `PBC_CLK_HZ / `PBC_MS_PER_S
)(
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire powerButtonIn,
  input wire buttonModeSelect,
  input wire [1:0] defaultDebounceSelect,
  input wire [1:0] defaultLongPressDelay,
  input wire systemOn,
  input wire powerDownDone,
  output reg powerOnReq,
  output reg offHold,
  output reg turnOffReq,
  output reg powerDownReq,
  output reg powerUpReq,
  output reg irqOutN
);

  localparam DISCH_CYCLES =
    `PBC_DISCHARGE_US * (`PBC_CLK_HZ / `PBC_US_PER_S);

  localparam S_IDLE = 2'h0;
  localparam S_PDOWN = 2'h1;
  localparam S_DISCH = 2'h2;
  localparam S_PUP = 2'h3;

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [16:0] msCnt_ff;
  reg msTick_ff;
  reg dbLevel_ff;
  reg [9:0] dbCnt_ff;
  reg [13:0] holdCnt_ff;
  reg [6:0] irqStatus_ff;
  reg [6:0] irqMask_ff;
  reg [1:0] debounceSelect_ff;
  reg [1:0] longPressDelaySelect_ff;
  reg longPressResetSelect_ff;
  reg [1:0] seq_ff;
  reg [11:0] dischCnt_ff;

  reg [1:0] nxt_seq;
  reg [9:0] dbThr;
  reg [13:0] delayThr;
  reg [31:0] rdData;
  reg rdErr;

  wire [6:0] holdHit;
  wire [6:0] irqSet;
  wire [6:0] irqClr;
  wire [9:0] dbCntInc;
  wire [13:0] holdInc;
  wire dbFall;
  wire dbRise;
  wire pressed;
  wire longPress;
  wire apbAccess;
  wire apbCommit;

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      msCnt_ff <= 17'h00000;
      msTick_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      msTick_ff <= (msCnt_ff == MS_CYCLES - 1);
      if (msCnt_ff == MS_CYCLES - 1)
        msCnt_ff <= 17'h00000;
      else
        msCnt_ff <= msCnt_ff + 17'h00001;
    end
  end

  // ----------------------------------------
  // debounce
  // ----------------------------------------
  always @*
  begin
    case (debounceSelect_ff)
      2'h2: dbThr = `PBC_DBNC_125_MS;
      2'h3: dbThr = `PBC_DBNC_750_MS;
      default: dbThr = `PBC_DBNC_32_MS;
    endcase
    if (dbLevel_ff == 1'b0)
      dbThr = `PBC_DBNC_RISE_MS;
  end

  assign dbCntInc = dbCnt_ff + 10'h001;
  assign dbFall = msTick_ff && dbLevel_ff && !powerButtonIn &&
    dbCntInc == dbThr;
  assign dbRise = msTick_ff && !dbLevel_ff && powerButtonIn &&
    dbCntInc == dbThr;

  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      dbLevel_ff <= 1'b1;
      dbCnt_ff <= 10'h000;
    end
    else if (clkEn)
    begin
      // a bounce back to the settled level restarts the window
      if (powerButtonIn == dbLevel_ff)
        dbCnt_ff <= 10'h000;
      else if (dbFall || dbRise)
      begin
        dbCnt_ff <= 10'h000;
        dbLevel_ff <= powerButtonIn;
      end
      else if (msTick_ff)
        dbCnt_ff <= dbCntInc;
    end
  end

  // ----------------------------------------
  // hold timer
  // ----------------------------------------
  // level mode has no filter, so the raw pin is timed there
  assign pressed = buttonModeSelect ? !dbLevel_ff : !powerButtonIn;
  assign holdInc = holdCnt_ff + 14'h0001;

  always @(posedge sys_clk)
  begin
    if (!resetn)
      holdCnt_ff <= 14'h0000;
    else if (clkEn)
    begin
      if (!pressed)
        holdCnt_ff <= 14'h0000;
      else if (msTick_ff && holdCnt_ff != `PBC_HOLD_MAX)
        holdCnt_ff <= holdInc;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_hold
      localparam [13:0] THR = (gi == 0) ? `PBC_HOLD_1S_MS :
        (gi == 1) ? `PBC_HOLD_2S_MS :
        (gi == 2) ? `PBC_HOLD_3S_MS :
        (gi == 3) ? `PBC_HOLD_4S_MS : `PBC_HOLD_8S_MS;
      // equality on the step fires once per press
      assign holdHit[`PBC_IRQ_HOLD_BASE + gi] = pressed && msTick_ff &&
        holdCnt_ff != `PBC_HOLD_MAX && holdInc == THR;
    end
  endgenerate

  assign holdHit[1:0] = 2'b00;

  always @*
  begin
    case (longPressDelaySelect_ff)
      2'h0: delayThr = `PBC_HOLD_2S_MS;
      2'h1: delayThr = `PBC_HOLD_4S_MS;
      2'h2: delayThr = `PBC_HOLD_8S_MS;
      default: delayThr = `PBC_HOLD_16S_MS;
    endcase
  end

  // long press only acts in system-on; in off modes a held
  // button must not restart or turn off a device already off
  assign longPress = pressed && msTick_ff && systemOn &&
    holdCnt_ff != `PBC_HOLD_MAX && holdInc == delayThr;

  // ----------------------------------------
  // interrupt latches
  // ----------------------------------------
  assign irqSet[`PBC_IRQ_PRESS] = buttonModeSelect && systemOn && dbFall;
  assign irqSet[`PBC_IRQ_RELEASE] = buttonModeSelect && systemOn && dbRise;
  assign irqSet[6:2] = holdHit[6:2];

  // clears act only at the completing handshake edge
  assign apbAccess = psel && penable && !pready;
  assign apbCommit = psel && penable && pready;
  assign irqClr = (apbCommit && pwrite && paddr == `PBC_ADDR_IRQ_STATUS) ?
    pwdata[6:0] : 7'h00;

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  // the power-down itself lives outside this block; we only
  // request it and wait for the done flag, so a stuck done
  // input parks the sequencer in the power-down state
  always @*
  begin
    nxt_seq = seq_ff;
    case (seq_ff)
      S_IDLE:
        if (longPress && longPressResetSelect_ff)
          nxt_seq = S_PDOWN;
      S_PDOWN:
        if (powerDownDone)
          nxt_seq = S_DISCH;
      S_DISCH:
        if (dischCnt_ff == DISCH_CYCLES - 1)
          nxt_seq = S_PUP;
      S_PUP:
        nxt_seq = S_IDLE;
      default:
        nxt_seq = S_IDLE;
    endcase
  end

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  always @*
  begin
    rdData = 32'h00000000;
    rdErr = 1'b0;
    case (paddr)
      `PBC_ADDR_IRQ_STATUS: rdData[6:0] = irqStatus_ff;
      `PBC_ADDR_IRQ_MASK: rdData[6:0] = irqMask_ff;
      `PBC_ADDR_SENSE:
      begin
        rdData[`PBC_SENSE_BIT] = !powerButtonIn;
        rdData[`PBC_SENSE_MODE] = buttonModeSelect;
      end
      `PBC_ADDR_CTRL:
      begin
        rdData[1:0] = debounceSelect_ff;
        rdData[3:2] = longPressDelaySelect_ff;
        rdData[`PBC_CTRL_RSTSEL] = longPressResetSelect_ff;
      end
      default: rdErr = 1'b1;
    endcase
  end

  // ----------------------------------------
  // registers, bus and outputs
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irqStatus_ff <= 7'h00;
      irqMask_ff <= `PBC_MASK_RESET;
      // synchronous reset, so loading the strap inputs is safe
      debounceSelect_ff <= defaultDebounceSelect;
      longPressDelaySelect_ff <= defaultLongPressDelay;
      longPressResetSelect_ff <= `PBC_RSTSEL_RESET;
      seq_ff <= S_IDLE;
      dischCnt_ff <= 12'h000;
      powerOnReq <= 1'b0;
      offHold <= 1'b0;
      turnOffReq <= 1'b0;
      powerDownReq <= 1'b0;
      powerUpReq <= 1'b0;
      irqOutN <= 1'b1;
    end
    else if (clkEn)
    begin
      // one wait state: answer is registered, write lands on handshake
      pready <= apbAccess;
      if (apbAccess)
      begin
        prdata <= pwrite ? 32'h00000000 : rdData;
        pslverr <= rdErr;
      end
      if (apbCommit && pwrite)
      begin
        if (paddr == `PBC_ADDR_IRQ_MASK)
          irqMask_ff <= pwdata[6:0];
        if (paddr == `PBC_ADDR_CTRL)
        begin
          debounceSelect_ff <= pwdata[1:0];
          longPressDelaySelect_ff <= pwdata[3:2];
          longPressResetSelect_ff <= pwdata[`PBC_CTRL_RSTSEL];
        end
      end
      // set wins over a same-cycle clear
      irqStatus_ff <= (irqStatus_ff & ~irqClr) | irqSet;
      irqOutN <= ~|(irqStatus_ff & ~irqMask_ff);

      seq_ff <= nxt_seq;
      if (seq_ff == S_DISCH)
        dischCnt_ff <= dischCnt_ff + 12'h001;
      else
        dischCnt_ff <= 12'h000;
      powerDownReq <= (seq_ff == S_IDLE) && (nxt_seq == S_PDOWN);
      powerUpReq <= (seq_ff == S_PUP);
      if (seq_ff == S_PUP)
      begin
        debounceSelect_ff <= defaultDebounceSelect;
        longPressDelaySelect_ff <= defaultLongPressDelay;
        longPressResetSelect_ff <= `PBC_RSTSEL_RESET;
      end
      turnOffReq <= longPress && !longPressResetSelect_ff;

      offHold <= !buttonModeSelect && !powerButtonIn;
      if (!buttonModeSelect)
        powerOnReq <= powerButtonIn && !systemOn;
      else
        powerOnReq <= dbFall && !systemOn;
    end
  end

endmodule

// file: sim/pbc_power_button_monitor.sv
`timescale 1ns/1ps
module pbc_power_button_monitor #(
  parameter MS_CYCLES = 10
)(
  input wire sys_clk,
  input wire resetn,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire powerButtonIn,
  input wire buttonModeSelect,
  input wire systemOn,
  input wire powerDownDone,
  input wire powerOnReq,
  input wire offHold,
  input wire turnOffReq,
  input wire powerDownReq,
  input wire powerUpReq,
  input wire irqOutN
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // helper: cycles since power-down finished
  // ----------------------------------------
  // too long for a delay range, so count it here
  reg [11:0] upGap_ff;
  reg downDoneDly_ff;
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      upGap_ff <= 12'h000;
      downDoneDly_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      downDoneDly_ff <= powerDownDone;
      if (powerDownDone && !downDoneDly_ff)
        upGap_ff <= 12'h001;
      else if (upGap_ff != 12'h000 && upGap_ff != 12'hFFF)
        upGap_ff <= upGap_ff + 12'h001;
    end
  end
  a_level_off: assert property (clkEn |=>
    offHold == (!$past(buttonModeSelect) && !$past(powerButtonIn)))
    else $error("offHold wrong");
  a_level_on: assert property (clkEn && !buttonModeSelect |=>
    powerOnReq == ($past(powerButtonIn) && !$past(systemOn)))
    else $error("level powerOnReq wrong");
  a_press_pulse: assert property (buttonModeSelect && powerOnReq |->
    !$past(systemOn) ##1 !powerOnReq) else $error("powerOnReq pulse");
  a_apb_wait: assert property (clkEn && psel && penable && !pready |=>
    pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_turnoff_on: assert property (turnOffReq |->
    $past(systemOn) ##1 !turnOffReq) else $error("turnOffReq wrong");
  a_down_pulse: assert property (powerDownReq |->
    !turnOffReq ##1 !powerDownReq) else $error("powerDownReq wrong");
  // supplies discharge for 3000 cycles before the restart pulse
  a_up_gap: assert property ($rose(powerUpReq) |->
    upGap_ff >= 12'hBAE && upGap_ff <= 12'hBC2)
    else $error("powerUpReq gap");
endmodule

// file: sim/pbc_button_model.sv
`timescale 1ns/1ps
module pbc_button_model (
  input wire pressed,
  output wire powerButtonIn
);
  // open switch: the pull-up holds the pin high
  assign powerButtonIn = pressed ? 1'b0 : 1'b1;
endmodule

// file: sim/pbc_power_button_controller_test.sv
`timescale 1ns/1ps
`include "pbc_consts.vh"
module pbc_power_button_controller_test;
  // short ms tick keeps the 8 s holds within the run budget
  localparam MS = 2;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg pressed = 1'b0;
  reg mode = 1'b0;
  reg sysOn = 1'b0;
  reg downDone = 1'b0;
  reg [31:0] rd;
  reg err;
  int n;
  int n_errors = 0;
  int n_tests = 0;
  wire [31:0] prdata;
  wire pready, pslverr, pin, powerOnReq, offHold, turnOffReq;
  wire powerDownReq, powerUpReq, irqOutN;
  wire [4:0] evt;
  assign evt = {powerUpReq, powerDownReq, turnOffReq, powerOnReq, ~irqOutN};
  pbc_power_button_controller #(.MS_CYCLES(MS))
  pbc_power_button_controller_inst (
    .sys_clk(sys_clk), .resetn(resetn), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .powerButtonIn(pin), .buttonModeSelect(mode),
    .defaultDebounceSelect(2'h3), .defaultLongPressDelay(2'h0),
    .systemOn(sysOn), .powerDownDone(downDone), .powerOnReq(powerOnReq),
    .offHold(offHold), .turnOffReq(turnOffReq),
    .powerDownReq(powerDownReq), .powerUpReq(powerUpReq),
    .irqOutN(irqOutN)
  );
  pbc_button_model pbc_button_model_inst (
    .pressed(pressed),
    .powerButtonIn(pin)
  );
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task stop_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task chkr(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task apb(input bit wr, input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input [7:0] a, input [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task press(input bit p);
    @(posedge sys_clk);
    pressed <= p;
  endtask
  // counts edges until the selected evt bit is high, giving up after 40000
  task wait_evt(input int b);
    n = 0;
    while (evt[b] !== 1'b1 && n < 40000)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task t_level;
    press(1'b1);
    repeat (3) @(posedge sys_clk);
    chk("offHold", 1, offHold);
    chk("powerOnReq", 0, powerOnReq);
    rdchk(`PBC_ADDR_SENSE, 32'h1, "sense");
    press(1'b0);
    repeat (3) @(posedge sys_clk);
    chk("offHold", 0, offHold);
    chk("powerOnReq", 1, powerOnReq);
  endtask
  task t_regs;
    rdchk(`PBC_ADDR_IRQ_MASK, 32'h7F, "mask");
    rdchk(`PBC_ADDR_IRQ_STATUS, 32'h0, "status");
    rdchk(`PBC_ADDR_CTRL, 32'h3, "ctrl");
    rdchk(`PBC_ADDR_SENSE, 32'h2, "sense");
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("pslverr", 1, err);
  endtask
  task t_dbnc;
    int t[4] = '{32, 32, 125, 750};
    sysOn <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `PBC_ADDR_CTRL, 32'(s));
      apb(1'b1, `PBC_ADDR_IRQ_MASK, 32'h7E);
      press(1'b1);
      wait_evt(0);
      chkr("fall", (t[s] - 1) * MS, (t[s] + 1) * MS + 4, n);
      apb(1'b1, `PBC_ADDR_IRQ_MASK, 32'h7D);
      rdchk(`PBC_ADDR_IRQ_STATUS, 32'h1, "press");
      chk("masked", 1, irqOutN);
      apb(1'b1, `PBC_ADDR_IRQ_STATUS, 32'h1);
      press(1'b0);
      wait_evt(0);
      chkr("rise", 31 * MS, 33 * MS + 4, n);
      apb(1'b1, `PBC_ADDR_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk("cleared", 1, irqOutN);
    end
  endtask
  task t_hold;
    apb(1'b1, `PBC_ADDR_CTRL, 32'h0);
    apb(1'b1, `PBC_ADDR_IRQ_MASK, 32'h7F);
    press(1'b1);
    wait_evt(2);
    chkr("turnOff", 2030 * MS, 2034 * MS + 4, n);
    repeat (6100 * MS) @(posedge sys_clk);
    rdchk(`PBC_ADDR_IRQ_STATUS, 32'h7D, "holds");
    apb(1'b1, `PBC_ADDR_IRQ_STATUS, 32'h7F);
    repeat (100 * MS) @(posedge sys_clk);
    rdchk(`PBC_ADDR_IRQ_STATUS, 32'h0, "once");
    press(1'b0);
    repeat (40 * MS) @(posedge sys_clk);
    rdchk(`PBC_ADDR_IRQ_STATUS, 32'h2, "release");
  endtask
  task t_restart;
    apb(1'b1, `PBC_ADDR_CTRL, 32'h15);
    press(1'b1);
    wait_evt(3);
    chkr("powerDown", 4030 * MS, 4034 * MS + 4, n);
    press(1'b0);
    repeat (5) @(posedge sys_clk);
    downDone <= 1'b1;
    wait_evt(4);
    chkr("powerUp", 2990, 3010, n);
    downDone <= 1'b0;
    rdchk(`PBC_ADDR_CTRL, 32'h3, "reload");
    sysOn <= 1'b0;
    press(1'b1);
    wait_evt(1);
    chkr("powerOn", 749 * MS, 751 * MS + 4, n);
    press(1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_level;
    mode <= 1'b1;
    resetn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs;
    t_dbnc;
    t_hold;
    t_restart;
    stop_test;
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    stop_test;
  end
endmodule
bind pbc_power_button_controller pbc_power_button_monitor #(
  .MS_CYCLES(MS_CYCLES)
) pbc_power_button_monitor_inst (
  .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .psel(psel),
  .penable(penable), .pready(pready), .powerButtonIn(powerButtonIn),
  .buttonModeSelect(buttonModeSelect), .systemOn(systemOn),
  .powerDownDone(powerDownDone), .powerOnReq(powerOnReq),
  .offHold(offHold), .turnOffReq(turnOffReq),
  .powerDownReq(powerDownReq), .powerUpReq(powerUpReq), .irqOutN(irqOutN)
);
